// ==== core/line_performance_counters.sv ====
/*
  Performance monitor counters for a T1 receive path with holding
  registers and transfer status, reached over a plain register port.
  Assumes framer event strobes come from other clock domains and are
  active-high pulses, one event per rising edge, wider than two system clocks.
*/
// Summary of operation
// - After counts move into holding registers, set transfer-done in status bit 1.
// - Reading status clears transfer-done, acknowledging the transfer.
// - A transfer while transfer-done still set sets overrun in bit 0.
// - Reading status clears overrun; it reads zero when no overrun.
// - A write to any count address latches all counters as one group.
// - Latch and counter reset align with event timing; no event lost or doubled.
// - Holding registers hold new data within 3.5 recovered clock periods.
// - Holding contents are undefined after reset until first latch.
// - Holding registers read at the same count addresses.
// - Violation counter is 12 bits; low byte at 4AH.
// - Upper four violation bits in 4BH bits 3..0; bits 7..4 unused.
// - Violation counter steps once per bipolar violation.
// - Bit error counter is 9 bits; low byte 4CH, top bit 4DH bit 0.
// - One bit error per CRC-6 error in extended superframe, per superframe F-bit error.
// - Loop-carrier Ft errors count one; multiplexed format counts up to 7 per frame.
// - Framing bit error counter is 5 bits, latched in the same group.
// - 3-bit counter counts out-of-frame or alignment changes, chosen by select bit.
`timescale 1ns/1ps
module line_performance_counters
  import perf_mon_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic bipolar_violation_i,
  input wire logic bit_error_event_i,
  input wire logic [BITERR_STEP_W-1:0] bit_error_weight_i,
  input wire logic framing_bit_error_i,
  input wire logic out_of_frame_i,
  input wire logic alignment_change_i
);
  localparam int NEV = 5;

  function automatic logic is_count_addr(input logic [ADDR_W-1:0] a);
    is_count_addr = (a >= OFF_VIOL_LO) && (a <= OFF_ALIGN);
  endfunction : is_count_addr

  // Two-stage synchronisers; stage one feeds stage two only
  logic [NEV-1:0] ev_raw;
  wire logic [NEV-1:0] ev_pulse;
  assign ev_raw = {alignment_change_i, out_of_frame_i, framing_bit_error_i,
                   bit_error_event_i, bipolar_violation_i};

  // Flops local to each channel, so every process owns all that it writes
  genvar g;
  generate
    for (g = 0; g < NEV; g++)
    begin : g_sync
      logic sync_a;
      logic sync_b;
      logic sync_c;
      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i)
        begin
          sync_a <= 1'b0;
          sync_b <= 1'b0;
          sync_c <= 1'b0;
        end
        else
        begin
          sync_a <= ev_raw[g];
          sync_b <= sync_a;
          sync_c <= sync_b;
        end
      end
      assign ev_pulse[g] = sync_b & ~sync_c;
    end
  endgenerate

  // Weight also crosses domains; sampled via its own two flops
  // Quasi-static: the framer holds it steady around each event edge
  logic [BITERR_STEP_W-1:0] wt_a;
  logic [BITERR_STEP_W-1:0] wt_b;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wt_a <= '0;
      wt_b <= '0;
    end
    else
    begin
      wt_a <= bit_error_weight_i;
      wt_b <= wt_a;
    end
  end

  // Control register: selects alignment-change counting
  logic [DATA_W-1:0] ctrl;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      ctrl <= CTRL_RESET;
    else if (wr_i && addr_i == OFF_CTRL)
      ctrl <= wdata_i;
  end

  // Latch sequencer
  latch_state_t state;
  latch_state_t next_state;
  logic clear_pulse;
  always_comb
  begin
    next_state = state;
    case (state)
      LATCH_IDLE:
        if (wr_i && is_count_addr(addr_i))
          next_state = LATCH_WAIT;
      LATCH_WAIT:
        next_state = LATCH_MOVE;
      LATCH_MOVE:
        next_state = LATCH_IDLE;
      default:
        next_state = LATCH_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      state <= LATCH_IDLE;
    else
      state <= next_state;
  end
  // Wait state lets in-flight synchronised events land before the copy
  assign clear_pulse = (state == LATCH_MOVE);

  // Counters
  logic [BITERR_STEP_W-1:0] bit_error_step;
  logic [VIOL_W-1:0] line_code_violation_count;
  logic [BITERR_W-1:0] bit_error_event_count;
  logic [FRAMING_W-1:0] framing_bit_error_count;
  logic [ALIGN_W-1:0] out_of_frame_count;
  logic frame_loss_step;
  // Superframe, extended superframe and loop-carrier frames weigh 1;
  // the multiplexed-format framer reports up to 7 per frame
  assign bit_error_step = ev_pulse[1] ? ((wt_b == 3'h0) ? 3'h1 : wt_b) : 3'h0;
  assign frame_loss_step = ctrl[BIT_SEL_ALIGN] ? ev_pulse[4] : ev_pulse[3];

  sat_event_counter #(.W(VIOL_W), .SW(1)) u_viol (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clear_i(clear_pulse),
    .step_i(ev_pulse[0]),
    .count_o(line_code_violation_count)
  );
  sat_event_counter #(.W(BITERR_W), .SW(BITERR_STEP_W)) u_biterr (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clear_i(clear_pulse),
    .step_i(bit_error_step),
    .count_o(bit_error_event_count)
  );
  sat_event_counter #(.W(FRAMING_W), .SW(1)) u_framing (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clear_i(clear_pulse),
    .step_i(ev_pulse[2]),
    .count_o(framing_bit_error_count)
  );
  sat_event_counter #(.W(ALIGN_W), .SW(1)) u_frame_loss (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clear_i(clear_pulse),
    .step_i(frame_loss_step),
    .count_o(out_of_frame_count)
  );

  // Holding registers; no reset, contents meaningless until first latch
  logic [VIOL_W-1:0] hold_viol;
  logic [BITERR_W-1:0] hold_biterr;
  logic [FRAMING_W-1:0] hold_framing;
  logic [ALIGN_W-1:0] hold_frame_loss;
  always_ff @(posedge sys_clk_i)
  begin
    if (clear_pulse)
    begin
      hold_viol <= line_code_violation_count;
      hold_biterr <= bit_error_event_count;
      hold_framing <= framing_bit_error_count;
      hold_frame_loss <= out_of_frame_count;
    end
  end

  // Status flags; a transfer in the read cycle wins over the clear of transfer-done, but the read clears overrun
  logic transfer_done_flag;
  logic holding_overrun_flag;
  logic status_rd;
  assign status_rd = rd_i && (addr_i == OFF_STATUS);
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      transfer_done_flag <= 1'b0;
    else if (clear_pulse)
      transfer_done_flag <= 1'b1;
    else if (status_rd)
      transfer_done_flag <= 1'b0;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      holding_overrun_flag <= 1'b0;
    else if (clear_pulse && transfer_done_flag && !status_rd)
      holding_overrun_flag <= 1'b1;
    else if (status_rd)
      holding_overrun_flag <= 1'b0;
  end

  // Reserved bit stored as written; software keeps it zero
  logic rsvd_bit;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      rsvd_bit <= STATUS_RESET[BIT_RSVD];
    else if (wr_i && addr_i == OFF_STATUS)
      rsvd_bit <= wdata_i[BIT_RSVD];
  end

  // Read data, one cycle after the strobe, zero otherwise
  logic [DATA_W-1:0] next_rdata;
  always_comb
  begin
    next_rdata = '0;
    if (rd_i)
    begin
      case (addr_i)
        OFF_STATUS: next_rdata = {5'h00, rsvd_bit, transfer_done_flag, holding_overrun_flag};
        OFF_VIOL_LO: next_rdata = hold_viol[7:0];
        OFF_VIOL_HI: next_rdata = {4'h0, hold_viol[11:8]};
        OFF_BITERR_LO: next_rdata = hold_biterr[7:0];
        OFF_BITERR_HI: next_rdata = {7'h00, hold_biterr[8]};
        OFF_FRAMING: next_rdata = {3'h0, hold_framing};
        OFF_ALIGN: next_rdata = {5'h00, hold_frame_loss};
        OFF_CTRL: next_rdata = ctrl;
        default: next_rdata = '0;
      endcase
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      rdata_o <= '0;
    else
      rdata_o <= next_rdata;
  end

  // Helper: cycles since latch write
  logic [7:0] since_wr;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || (state == LATCH_IDLE && wr_i && is_count_addr(addr_i)))
      since_wr <= 8'h00;
    else if (since_wr != 8'hff)
      since_wr <= since_wr + 8'h01;
  end

  chk_latch_deadline: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state == LATCH_IDLE && wr_i && is_count_addr(addr_i)) |-> ##2 clear_pulse)
    else $error("latch not done in time");
  chk_latch_bound: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clear_pulse |-> (since_wr <= 8'(LATCH_MAX_CYC)))
    else $error("latch exceeded deadline");
  chk_done_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clear_pulse |=> transfer_done_flag)
    else $error("transfer flag not set");
  chk_done_holds: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (transfer_done_flag && !status_rd) |=> transfer_done_flag)
    else $error("transfer flag dropped without read");
  chk_done_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (status_rd && !clear_pulse) |=> !transfer_done_flag)
    else $error("transfer flag not cleared by read");
  chk_overrun_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clear_pulse && transfer_done_flag && !status_rd) |=> holding_overrun_flag)
    else $error("overrun not flagged");
  chk_overrun_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    status_rd |=> !holding_overrun_flag)
    else $error("overrun not cleared by read");
  chk_hold_copy: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clear_pulse |=> (hold_viol == $past(line_code_violation_count) &&
                     hold_biterr == $past(bit_error_event_count) &&
                     hold_framing == $past(framing_bit_error_count)))
    else $error("holding copy wrong");
  chk_count_restart: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clear_pulse |=> (line_code_violation_count == VIOL_W'($past(ev_pulse[0]))))
    else $error("event in clear cycle lost");
  chk_viol_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (rd_i && addr_i == OFF_VIOL_HI) |=> (rdata_o[7:4] == 4'h0))
    else $error("unused bits not zero");
  chk_framing_sat: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (framing_bit_error_count == 5'h1f && !clear_pulse) |=> (framing_bit_error_count == 5'h1f))
    else $error("counter wrapped");
endmodule : line_performance_counters

// ==== core/perf_mon_pkg.sv ====
/*
  Constants for the line performance counter block: register offsets,
  field positions, counter widths and latch timing.
  Assumes an 8-bit register port and a 50 MHz system clock.
*/
package perf_mon_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFF_STATUS = 8'h49;
  localparam logic [7:0] OFF_VIOL_LO = 8'h4a;
  localparam logic [7:0] OFF_VIOL_HI = 8'h4b;
  localparam logic [7:0] OFF_BITERR_LO = 8'h4c;
  localparam logic [7:0] OFF_BITERR_HI = 8'h4d;
  localparam logic [7:0] OFF_FRAMING = 8'h4e;
  localparam logic [7:0] OFF_ALIGN = 8'h4f;
  localparam logic [7:0] OFF_CTRL = 8'h40;
  localparam int BIT_OVERRUN = 0;
  localparam int BIT_DONE = 1;
  localparam int BIT_RSVD = 2;
  localparam int BIT_SEL_ALIGN = 0;
  localparam int VIOL_W = 12;
  localparam int BITERR_W = 9;
  localparam int FRAMING_W = 5;
  localparam int ALIGN_W = 3;
  localparam int BITERR_STEP_W = 3;
  localparam logic [2:0] BITERR_STEP_MAX = 3'h7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Latch deadline: 3.5 recovered periods at 1.544 MHz
  localparam int SYS_CLK_HZ = 50000000;
  localparam int LATCH_MAX_NS = 2266;
  localparam int LATCH_MAX_CYC = (LATCH_MAX_NS * (SYS_CLK_HZ / 1000000)) / 1000;
  typedef enum logic [1:0] {
    LATCH_IDLE = 2'b00,
    LATCH_WAIT = 2'b01,
    LATCH_MOVE = 2'b11
  } latch_state_t;
endpackage : perf_mon_pkg

// ==== core/sat_event_counter.sv ====
/*
  Saturating event counter with a clear that is applied atomically with
  an increment, so an event in the clearing cycle starts the new period.
  Assumes step and clear come from the system clock domain.
*/
`timescale 1ns/1ps
module sat_event_counter #(
  parameter int W = 8,
  parameter int SW = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic [SW-1:0] step_i,
  output logic [W-1:0] count_o
);
  logic [W:0] sum;
  logic [W-1:0] max_val;
  assign max_val = '1;
  assign sum = (clear_i ? {(W+1){1'b0}} : {1'b0, count_o}) + (W+1)'(step_i);
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      count_o <= '0;
    else if (sum > {1'b0, max_val})
      count_o <= max_val; // Saturate
    else
      count_o <= sum[W-1:0]; // Event in clear cycle lands in new period
  end
endmodule : sat_event_counter

// ==== tb/framer_event_source.sv ====
/*
  Behavioural framer event source driving the counter block's event pins.
  Assumes the bench calls emit from its own processes, one channel each.
*/
`timescale 1ns/1ps
module framer_event_source (
  input wire logic sys_clk_i,
  output logic bipolar_violation_o,
  output logic bit_error_event_o,
  output logic [2:0] bit_error_weight_o,
  output logic framing_bit_error_o,
  output logic out_of_frame_o,
  output logic alignment_change_o
);
  logic [4:0] ev = 5'h00;
  assign bipolar_violation_o = ev[0];
  assign bit_error_event_o = ev[1];
  assign framing_bit_error_o = ev[2];
  assign out_of_frame_o = ev[3];
  assign alignment_change_o = ev[4];
  initial bit_error_weight_o = 3'h1;

  // Three clocks high and six low between pulses, wider than the two-stage synchroniser needs
  task automatic emit(input int sel, input int n, input logic [2:0] w);
    repeat (n)
    begin
      @(posedge sys_clk_i);
      if (sel == 1)
        bit_error_weight_o <= w;
      repeat (3) @(posedge sys_clk_i);
      ev[sel] <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      ev[sel] <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
    end
  endtask : emit
endmodule : framer_event_source

// ==== tb/line_performance_counters_tb.sv ====
/*
  Self-checking bench for the performance counter block.
  Assumes the framer event source model and the design package.
*/
`timescale 1ns/1ps
module line_performance_counters_tb;
  import perf_mon_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic viol_ev;
  logic biterr_ev;
  logic framing_ev;
  logic frame_loss_ev;
  logic align_ev;
  logic [2:0] weight;
  logic [7:0] d;
  logic [7:0] d2;
  // 2.3 us of settling at 20 ns a clock before counts are polled
  localparam int POLL_WAIT_CYC = 115;
  int mismatches = 0;
  int checks = 0;

  line_performance_counters u_line_performance_counters (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bipolar_violation_i(viol_ev),
    .bit_error_event_i(biterr_ev), .bit_error_weight_i(weight),
    .framing_bit_error_i(framing_ev), .out_of_frame_i(frame_loss_ev),
    .alignment_change_i(align_ev)
  );
  framer_event_source u_framer_event_source (
    .sys_clk_i(sys_clk_i), .bipolar_violation_o(viol_ev), .bit_error_event_o(biterr_ev),
    .bit_error_weight_o(weight), .framing_bit_error_o(framing_ev),
    .out_of_frame_o(frame_loss_ev), .alignment_change_o(align_ev)
  );

  initial
  begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic bus_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : bus_write

  // Read data stand only in the cycle after the strobe; taken just past that edge
  task automatic bus_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : bus_read

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    bus_read(a, v);
    checks++;
    if (v !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: addr %h read %h, want %h", $time, a, v, e);
    end
  endtask : rd_chk

  // Only one count address per poll, then the settling wait before polling
  task automatic latch(input logic [7:0] a);
    bus_write(a, 8'h00);
    repeat (POLL_WAIT_CYC) @(posedge sys_clk_i);
  endtask : latch

  task automatic counts(input logic [11:0] l, input logic [8:0] b,
                        input logic [4:0] f, input logic [2:0] o);
    rd_chk(OFF_VIOL_LO, l[7:0]);
    rd_chk(OFF_VIOL_HI, {4'h0, l[11:8]});
    rd_chk(OFF_BITERR_LO, b[7:0]);
    rd_chk(OFF_BITERR_HI, {7'h00, b[8]});
    rd_chk(OFF_FRAMING, {3'h0, f});
    rd_chk(OFF_ALIGN, {5'h00, o});
  endtask : counts

  task automatic scen_basic();
    rd_chk(OFF_STATUS, 8'h00);
    rd_chk(8'h60, 8'h00);
    bus_write(OFF_STATUS, 8'h00);
    fork
      u_framer_event_source.emit(0, 5, 3'h1);
      u_framer_event_source.emit(1, 3, 3'h2);
      u_framer_event_source.emit(2, 4, 3'h1);
      u_framer_event_source.emit(3, 2, 3'h1);
    join
    repeat (4) @(posedge sys_clk_i);
    latch(OFF_VIOL_LO);
    rd_chk(OFF_STATUS, 8'h02);
    rd_chk(OFF_STATUS, 8'h00);
    counts(12'h005, 9'h006, 5'h04, 3'h2);
  endtask : scen_basic

  task automatic scen_overrun();
    latch(OFF_ALIGN);
    latch(OFF_BITERR_LO);
    rd_chk(OFF_STATUS, 8'h03);
    rd_chk(OFF_STATUS, 8'h00);
    counts(12'h000, 9'h000, 5'h00, 3'h0);
  endtask : scen_overrun

  // Events keep arriving across a latch; the two periods must share them exactly
  task automatic scen_boundary();
    fork
      u_framer_event_source.emit(0, 20, 3'h1);
      begin
        repeat (85) @(posedge sys_clk_i);
        latch(OFF_VIOL_LO);
      end
    join
    repeat (4) @(posedge sys_clk_i);
    bus_read(OFF_VIOL_LO, d);
    latch(OFF_VIOL_HI);
    bus_read(OFF_VIOL_LO, d2);
    checks++;
    if ((d + d2) !== 8'h14 || d === 8'h00)
    begin
      mismatches++;
      $display("unexpected at %0t: split %h + %h, want 14 in total", $time, d, d2);
    end
    rd_chk(OFF_STATUS, 8'h03);
  endtask : scen_boundary

  task automatic scen_select();
    bus_write(OFF_CTRL, 8'h01);
    rd_chk(OFF_CTRL, 8'h01);
    fork
      u_framer_event_source.emit(4, 2, 3'h1);
      u_framer_event_source.emit(3, 3, 3'h1);
    join
    repeat (4) @(posedge sys_clk_i);
    latch(OFF_FRAMING);
    rd_chk(OFF_ALIGN, 8'h02);
    bus_write(OFF_CTRL, 8'h00);
    fork
      u_framer_event_source.emit(4, 2, 3'h1);
      u_framer_event_source.emit(3, 1, 3'h1);
    join
    repeat (4) @(posedge sys_clk_i);
    latch(OFF_VIOL_HI);
    rd_chk(OFF_ALIGN, 8'h01);
    rd_chk(OFF_STATUS, 8'h03);
  endtask : scen_select

  task automatic scen_saturate();
    fork
      u_framer_event_source.emit(0, 300, 3'h1);
      u_framer_event_source.emit(1, 74, 3'h7);
      u_framer_event_source.emit(2, 33, 3'h1);
      u_framer_event_source.emit(3, 9, 3'h1);
    join
    repeat (4) @(posedge sys_clk_i);
    latch(OFF_BITERR_HI);
    counts(12'h12c, 9'h1ff, 5'h1f, 3'h7);
  endtask : scen_saturate

  task automatic test_done();
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // All scenarios take about 4000 clocks, the 300-event burst most of them
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    test_done();
  end

  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    scen_basic();
    scen_overrun();
    scen_boundary();
    scen_select();
    scen_saturate();
    test_done();
  end
endmodule : line_performance_counters_tb
